// ===== verilog/spci_dev.sv
// Memory device end: pin sampling, clock gating, command decode, bursts and masking
//
// The address map and strobed register access were chosen for this implementation.
module spci_dev #(
    parameter int DQ_W = spci_pkg::DQ_W_DEF,
    parameter int IDX_W = 8
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Memory pins
    spci_if.dev_mp PINS,
    // Status
    output spci_pkg::spci_pwr_e POWER_STATE,
    output logic BURST_ACTIVE,
    output logic [spci_pkg::NBANK-1:0] BANK_OPEN,
    output logic [2:0] BURST_CODE
);
    import spci_pkg::*;
    localparam int COL_W = col_width(DQ_W);
    localparam int DEPTH = 1 << IDX_W;
    localparam int KEY_W = ADDR_W + BA_W + COL_W;

    spci_pwr_e pwr_r, pwr_nxt;
    logic cke_q_r;
    logic rx_on, clk_on;
    logic samp_r;
    spci_cmd_t cmd_r;
    logic [BA_W-1:0] ba_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DQ_W-1:0] dq_r;
    logic [1:0] dqm_r;
    logic [NBANK-1:0] open_r;
    logic [ADDR_W-1:0] row_r [NBANK];
    logic [2:0] bl_code_r;
    logic burst_act_r, burst_wr_r, burst_ap_r;
    logic [BA_W-1:0] burst_bank_r;
    logic [COL_W-1:0] burst_col_r;
    logic [LEFT_W-1:0] burst_left_r;
    logic [DQ_W-1:0] mem_r [DEPTH];
    logic [DQ_W-1:0] rd_stage_r, dq_out_r, dq_oe_r;
    logic rd_vld_r;
    logic [1:0] dqm_d_r;
    logic cmd_go, dec_act, dec_rw, dec_pre, dec_bst, dec_mrw;
    logic [LEFT_W-1:0] len;
    logic [COL_W-1:0] wrap_m, start_col, next_col;
    logic beat_go, beat_wr;
    logic [BA_W-1:0] beat_bank;
    logic [COL_W-1:0] beat_col;
    logic [KEY_W-1:0] key;
    logic [IDX_W-1:0] idx;
    logic [DQ_W-1:0] in_mask, out_mask;
    logic out_en;

    assign POWER_STATE = pwr_r;
    assign BURST_ACTIVE = burst_act_r;
    assign BANK_OPEN = open_r;
    assign BURST_CODE = bl_code_r;
    assign PINS.dev_dq_out = dq_out_r;
    assign PINS.dev_dq_oe = dq_oe_r;

    ////////////////////////////////////////////////////////////////////////////
    // Clock gate: gate seen high at one edge lets the next edge act
    assign rx_on = (pwr_r == PWR_RUN);
    assign clk_on = cke_q_r && rx_on;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cke_q_r <= CKE_RST;
        end else begin
            cke_q_r <= PINS.cke;
        end
    end

    // Power state; in the low-power modes the raw gate pin is read so the exit needs no live clock
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            PWR_RUN: begin
                if (cke_q_r && !PINS.cke) begin
                    if (burst_act_r || dec_rw) begin
                        pwr_nxt = PWR_HOLD;
                    end else if (open_r != '0) begin
                        pwr_nxt = PWR_PDN_ACT;
                    end else if ({PINS.cs_n, PINS.ras_n, PINS.cas_n, PINS.we_n} == CMD_REF) begin
                        pwr_nxt = PWR_SELF;
                    end else begin
                        pwr_nxt = PWR_PDN_PRE;
                    end
                end
            end
            PWR_HOLD: if (PINS.cke) begin
                pwr_nxt = PWR_RUN;
            end
            PWR_PDN_ACT, PWR_PDN_PRE, PWR_SELF: if (PINS.cke) begin
                pwr_nxt = PWR_RUN;
            end
            default: pwr_nxt = PWR_RUN;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pwr_r <= PWR_RUN;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input registers, rising edge only and only while the clock runs
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            samp_r <= 1'b0;
            cmd_r <= CMD_DESEL;
            ba_r <= '0;
            addr_r <= '0;
            dq_r <= '0;
            dqm_r <= '0;
        end else begin
            samp_r <= clk_on;
            if (clk_on) begin
                cmd_r <= {PINS.cs_n, PINS.ras_n, PINS.cas_n, PINS.we_n};
                ba_r <= PINS.bank_select_bits;
                addr_r <= PINS.multiplexed_address_bus;
                dq_r <= PINS.data_lines;
                dqm_r <= {PINS.high_byte_mask, PINS.low_byte_mask};
            end
        end
    end

    // Decode; select high masks every command
    assign cmd_go = samp_r && !cmd_r[3];
    assign dec_act = cmd_go && (cmd_r == CMD_ACT);
    assign dec_rw = cmd_go && ((cmd_r == CMD_RD) || (cmd_r == CMD_WR)) && open_r[ba_r];
    assign dec_pre = cmd_go && (cmd_r == CMD_PRE);
    assign dec_bst = cmd_go && (cmd_r == CMD_BST);
    assign dec_mrw = cmd_go && (cmd_r == CMD_MRW);

    // Burst geometry; sequential order wraps inside the burst
    assign len = bl_len(bl_code_r, COL_W);
    assign wrap_m = COL_W'(len - 12'h001);
    assign next_col = (burst_col_r & ~wrap_m) | ((burst_col_r + COL_W'(1)) & wrap_m);
    assign start_col = (DQ_W == 4) ? COL_W'({addr_r[11], addr_r[9:0]}) : addr_r[COL_W-1:0];

    // Current beat: a new access wins over a running burst
    always_comb begin
        beat_go = 1'b0;
        beat_wr = burst_wr_r;
        beat_bank = burst_bank_r;
        beat_col = next_col;
        if (dec_rw) begin
            beat_go = 1'b1;
            beat_wr = (cmd_r == CMD_WR);
            beat_bank = ba_r;
            beat_col = start_col;
        end else if (burst_act_r && samp_r && !dec_bst && (burst_left_r != '0)) begin
            beat_go = 1'b1;
        end
    end

    // Burst counter; only sampled edges advance it, so a held clock freezes it
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            burst_act_r <= 1'b0;
            burst_wr_r <= 1'b0;
            burst_ap_r <= 1'b0;
            burst_bank_r <= '0;
            burst_col_r <= '0;
            burst_left_r <= '0;
        end else if (dec_rw) begin
            burst_act_r <= 1'b1;
            burst_wr_r <= (cmd_r == CMD_WR);
            burst_ap_r <= addr_r[AP_BIT];
            burst_bank_r <= ba_r;
            burst_col_r <= start_col;
            burst_left_r <= len - 12'h001;
        end else if (dec_bst) begin
            burst_act_r <= 1'b0;
        end else if (burst_act_r && samp_r) begin
            if (burst_left_r == '0) begin
                burst_act_r <= 1'b0;
            end else begin
                burst_col_r <= next_col;
                burst_left_r <= burst_left_r - 12'h001;
            end
        end
    end

    // Rows, mode code and auto precharge at burst end
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            open_r <= '0;
            row_r <= '{default: '0};
            bl_code_r <= BL_RST;
        end else begin
            if (dec_act) begin
                open_r[ba_r] <= 1'b1;
                row_r[ba_r] <= addr_r;
            end
            if (dec_pre) begin
                if (addr_r[AP_BIT]) begin
                    open_r <= '0;
                end else begin
                    open_r[ba_r] <= 1'b0;
                end
            end
            if (burst_act_r && samp_r && (burst_left_r == '0) && burst_ap_r && !dec_rw) begin
                open_r[burst_bank_r] <= 1'b0;
            end
            if (dec_mrw) begin
                bl_code_r <= addr_r[BL_LSB +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte lane masks; narrow parts use the high mask for every line
    for (genvar i = 0; i < DQ_W; i++) begin : g_lane
        assign in_mask[i] = ((DQ_W == 16) && (i < 8)) ? dqm_r[0] : dqm_r[1];
        assign out_mask[i] = ((DQ_W == 16) && (i < 8)) ? dqm_d_r[0] : dqm_d_r[1];
    end

    // Storage is a small folded array; rows and columns alias above its depth
    assign key = {row_r[beat_bank], beat_bank, beat_col};
    assign idx = key[IDX_W-1:0];

    always_ff @(posedge SYS_CLK) begin
        if (beat_go && beat_wr) begin
            mem_r[idx] <= (mem_r[idx] & in_mask) | (dq_r & ~in_mask);
        end
    end

    // Output registers, frozen while the clock is held
    assign out_en = (pwr_r != PWR_HOLD);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_stage_r <= '0;
            rd_vld_r <= 1'b0;
            dqm_d_r <= '0;
            dq_out_r <= '0;
            dq_oe_r <= '0;
        end else if (out_en) begin
            rd_stage_r <= mem_r[idx];
            rd_vld_r <= beat_go && !beat_wr;
            dqm_d_r <= dqm_r;
            dq_out_r <= rd_stage_r;
            dq_oe_r <= {DQ_W{rd_vld_r}} & ~out_mask;
        end
    end
endmodule

// ===== verilog/spci_pkg.sv
// Shared constants and types for the SDRAM pin and command interface
package spci_pkg;
    // Bus geometry
    localparam int DQ_W_DEF = 16;
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int NBANK = 4;
    localparam int LEFT_W = 12;

    // Address field positions
    localparam int AP_BIT = 10;
    localparam int BL_LSB = 0;

    // Command codes, ordered {select, row strobe, column strobe, write strobe}, all active low
    typedef logic [3:0] spci_cmd_t;
    localparam spci_cmd_t CMD_DESEL = 4'hF;
    localparam spci_cmd_t CMD_NOP = 4'h7;
    localparam spci_cmd_t CMD_ACT = 4'h3;
    localparam spci_cmd_t CMD_RD = 4'h5;
    localparam spci_cmd_t CMD_WR = 4'h4;
    localparam spci_cmd_t CMD_BST = 4'h6;
    localparam spci_cmd_t CMD_PRE = 4'h2;
    localparam spci_cmd_t CMD_REF = 4'h1;
    localparam spci_cmd_t CMD_MRW = 4'h0;

    // Burst length codes in the mode operation code
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] BL_RST = 3'h0;

    // Read timing: command edge to first data on the lines
    localparam int CAS_LAT = 2;
    localparam int RD_PIPE = CAS_LAT + 1;

    // Reset values
    localparam logic CKE_RST = 1'b1;

    // Controller register offsets and fields
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_WDATA = 8'h04;
    localparam logic [7:0] OFF_RDATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CKE = 8'h10;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_BA_LSB = 4;
    localparam int CMD_ADDR_LSB = 16;
    localparam int WD_MASK_LSB = 16;
    localparam int ST_BEATS_LSB = 8;

    // Power and clock states, Gray coded along run, hold, power-down, self refresh
    typedef enum logic [2:0] {
        PWR_RUN = 3'h0,
        PWR_HOLD = 3'h1,
        PWR_PDN_ACT = 3'h3,
        PWR_PDN_PRE = 3'h2,
        PWR_SELF = 3'h6
    } spci_pwr_e;

    // Column width per data width variant
    function automatic int col_width(input int dq_w);
        if (dq_w == 16) begin
            return 9;
        end else if (dq_w == 8) begin
            return 10;
        end
        return 11;
    endfunction

    // Burst length in beats for a code
    function automatic logic [LEFT_W-1:0] bl_len(input logic [2:0] code, input int col_w);
        unique case (code)
            BL_1: return 12'h001;
            BL_2: return 12'h002;
            BL_4: return 12'h004;
            BL_8: return 12'h008;
            BL_PAGE: return LEFT_W'(1 << col_w);
            default: return 12'h001;
        endcase
    endfunction
endpackage

// ===== verilog/spci_if.sv
// Pin bundle joining the SDRAM controller and the memory device
interface spci_if #(parameter int DQ_W = spci_pkg::DQ_W_DEF);
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [spci_pkg::BA_W-1:0] bank_select_bits;
    logic [spci_pkg::ADDR_W-1:0] multiplexed_address_bus;
    logic low_byte_mask;
    logic high_byte_mask;
    logic [DQ_W-1:0] ctl_dq_out;
    logic [DQ_W-1:0] ctl_dq_oe;
    logic [DQ_W-1:0] dev_dq_out;
    logic [DQ_W-1:0] dev_dq_oe;
    logic [DQ_W-1:0] data_lines;

    // Wire level of the shared data lines; an undriven line reads low
    assign data_lines = (dev_dq_out & dev_dq_oe) | (ctl_dq_out & ctl_dq_oe & ~dev_dq_oe);

    modport ctrl_mp (
        output cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, multiplexed_address_bus,
        output low_byte_mask, high_byte_mask, ctl_dq_out, ctl_dq_oe,
        input data_lines
    );
    modport dev_mp (
        input cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, multiplexed_address_bus,
        input low_byte_mask, high_byte_mask, data_lines,
        output dev_dq_out, dev_dq_oe
    );
endinterface

// ===== verilog/spci_ctrl.sv
// Memory controller end: software register port driving the SDRAM pins
module spci_ctrl #(
    parameter int DQ_W = spci_pkg::DQ_W_DEF
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Software register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Memory pins
    spci_if.ctrl_mp PINS
);
    import spci_pkg::*;
    localparam int COL_W = col_width(DQ_W);

    spci_cmd_t cmd_r;
    logic [BA_W-1:0] ba_r;
    logic [ADDR_W-1:0] addr_r;
    logic cke_r;
    logic [DQ_W-1:0] wdata_r;
    logic [1:0] mask_r;
    logic [31:0] last_cmd_r;
    logic [DQ_W-1:0] rdata_r;
    logic [7:0] beats_r;
    logic [2:0] bl_code_r;
    logic drive_r;
    logic [LEFT_W-1:0] wr_left_r;
    logic [LEFT_W-1:0] rd_left_r;
    logic [RD_PIPE-1:0] rd_pipe_r;
    logic [31:0] reg_rdata_r;
    logic issue;
    spci_cmd_t new_cmd;
    logic [LEFT_W-1:0] new_len;

    assign issue = REG_WR && (REG_ADDR == OFF_CMD);
    assign new_cmd = REG_WDATA[CMD_CODE_LSB +: 4];
    assign new_len = bl_len(bl_code_r, COL_W);

    // Pins straight from flops
    assign {PINS.cs_n, PINS.ras_n, PINS.cas_n, PINS.we_n} = cmd_r;
    assign PINS.bank_select_bits = ba_r;
    assign PINS.multiplexed_address_bus = addr_r;
    assign PINS.cke = cke_r;
    assign PINS.low_byte_mask = mask_r[0];
    assign PINS.high_byte_mask = mask_r[1];
    assign PINS.ctl_dq_out = wdata_r;
    assign PINS.ctl_dq_oe = {DQ_W{drive_r}};
    assign REG_RDATA = reg_rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Command issue: one command per software write, no-operation otherwise
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_r <= CMD_DESEL;
            ba_r <= '0;
            addr_r <= '0;
            last_cmd_r <= '0;
        end else if (issue) begin
            cmd_r <= new_cmd;
            ba_r <= REG_WDATA[CMD_BA_LSB +: BA_W];
            addr_r <= REG_WDATA[CMD_ADDR_LSB +: ADDR_W];
            last_cmd_r <= REG_WDATA;
        end else begin
            cmd_r <= CMD_NOP;
        end
    end

    // Clock gate, write data and masks; gate resets high so no mode is entered by accident
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cke_r <= CKE_RST;
            wdata_r <= '0;
            mask_r <= '0;
        end else begin
            if (REG_WR && (REG_ADDR == OFF_CKE)) begin
                cke_r <= REG_WDATA[0];
            end
            if (REG_WR && (REG_ADDR == OFF_WDATA)) begin
                wdata_r <= REG_WDATA[DQ_W-1:0];
                mask_r <= REG_WDATA[WD_MASK_LSB +: 2];
            end
        end
    end

    // Burst length follows the last mode write this end issued
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bl_code_r <= BL_RST;
        end else if (issue && (new_cmd == CMD_MRW)) begin
            bl_code_r <= REG_WDATA[CMD_ADDR_LSB + BL_LSB +: 3];
        end
    end

    // Write burst: data driven with the command, then one beat per cycle
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            drive_r <= 1'b0;
            wr_left_r <= '0;
        end else if (issue && (new_cmd == CMD_WR)) begin
            drive_r <= 1'b1;
            wr_left_r <= new_len - 12'h001;
        end else if (issue && (new_cmd == CMD_BST)) begin
            drive_r <= 1'b0;
        end else if (drive_r) begin
            if (wr_left_r == '0) begin
                drive_r <= 1'b0;
            end else begin
                wr_left_r <= wr_left_r - 12'h001;
            end
        end
    end

    // Read burst: a token per beat, captured after the read latency
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_left_r <= '0;
            rd_pipe_r <= '0;
            rdata_r <= '0;
            beats_r <= '0;
        end else begin
            rd_pipe_r <= {rd_pipe_r[RD_PIPE-2:0], (rd_left_r != '0)};
            if (issue && (new_cmd == CMD_RD)) begin
                rd_left_r <= new_len;
            end else if (issue && (new_cmd == CMD_BST)) begin
                rd_left_r <= '0;
            end else if (rd_left_r != '0) begin
                rd_left_r <= rd_left_r - 12'h001;
            end
            if (rd_pipe_r[RD_PIPE-1]) begin
                rdata_r <= PINS.data_lines;
                beats_r <= beats_r + 8'h01;
            end
        end
    end

    // Register read, one cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            reg_rdata_r <= '0;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                OFF_CMD: reg_rdata_r <= last_cmd_r;
                OFF_WDATA: reg_rdata_r <= 32'({mask_r, 16'(wdata_r)});
                OFF_RDATA: reg_rdata_r <= 32'(rdata_r);
                OFF_STATUS: reg_rdata_r <= {16'h0000, beats_r, 5'h00, (rd_left_r != '0), drive_r, cke_r};
                OFF_CKE: reg_rdata_r <= {31'h00000000, cke_r};
                default: reg_rdata_r <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_r <= 32'h00000000;
        end
    end
endmodule

// ===== sim/spci_checker.sv
// Assertions on the pins between the controller and device ends
module spci_checker #(parameter int DQ_W = spci_pkg::DQ_W_DEF) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Command, address and mask pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [spci_pkg::ADDR_W-1:0] multiplexed_address_bus,
    input wire logic low_byte_mask,
    input wire logic high_byte_mask,
    // Data drivers
    input wire logic [DQ_W-1:0] ctl_dq_oe,
    input wire logic [DQ_W-1:0] dev_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import spci_pkg::*;
    logic [3:0] cmd;
    logic [2:0] bl_r;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////
    // Command code as the device decodes it
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    // Last loaded length code, so single-beat reads can be judged
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bl_r <= BL_RST;
        end else if (cke && cmd == CMD_MRW) begin
            bl_r <= multiplexed_address_bus[BL_LSB +: 3];
        end
    end
    ////////////////////////////////////////////////////////////////
    // Masks float their own lane two clocks on; enables are seen one sample after they are launched
    a_lo_mask_float: assert property (
        cke && $past(cke) && low_byte_mask ##1 cke |-> ##2 dev_dq_oe[7:0] == 8'h00)
        else $error("low lane not floated");
    a_hi_mask_float: assert property (
        cke && $past(cke) && high_byte_mask ##1 cke |-> ##2 dev_dq_oe[15:8] == 8'h00)
        else $error("high lane not floated");
    // Unmasked drive only starts two edges after a sampled read, seen at the third sample; a falling mask is excluded
    a_read_cause: assert property (
        $rose(dev_dq_oe[0]) && !$past(low_byte_mask, 3) && !$past(low_byte_mask, 4) |-> $past(cmd, 3) == CMD_RD)
        else $error("drive without read");
    a_lanes_paired: assert property (
        dev_dq_oe[7:0] inside {8'h00, 8'hFF} && dev_dq_oe[15:8] inside {8'h00, 8'hFF}) else $error("lane split");
    // Gate low holds the following edge, so the sample after that shows no change
    a_cke_freeze: assert property (!cke |-> ##2 $stable(dev_dq_oe)) else $error("outputs moved while stopped");
    a_no_clash: assert property ((ctl_dq_oe & dev_dq_oe) == '0) else $error("both ends drive");
    a_cmd_one_cycle: assert property (
        !cs_n && cmd != CMD_NOP |=> cmd == CMD_NOP) else $error("command held");
    a_single_beat: assert property (
        $rose(dev_dq_oe[15]) && bl_r == BL_1 && $past(cmd, 2) != CMD_RD |=> !dev_dq_oe[15]) else $error("long beat");
    // Main traffic seen
    c_read: cover property (cmd == CMD_RD);
    c_masked_write: cover property (cmd == CMD_WR && low_byte_mask);
    c_stop: cover property ($fell(cke));
endmodule

// ===== sim/tb_top.sv
// Bench joining both ends over the pin bundle, checked against a word model
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spci_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    spci_pwr_e pwr;
    logic [3:0] bank_open;
    logic burst_act;
    logic [2:0] burst_code;
    logic [15:0] mem [int];
    logic [2:0] codes [4] = '{BL_1, BL_2, BL_4, BL_8};
    int err_total = 0;
    int tests_run = 0;
    int dev_beats = 0;
    int base, b, dummy;
    spci_if #(.DQ_W(16)) pins ();
    ////////////////////////////////////////////////////////////////
    // Clock, and beats driven by the device counted mid-cycle
    always #4 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        dev_beats += int'(|pins.dev_dq_oe);
    end
    // Both ends and the pin checker
    spci_ctrl #(.DQ_W(16)) u_spci_ctrl (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PINS(pins));
    spci_dev #(.DQ_W(16), .IDX_W(8)) u_spci_dev (.SYS_CLK(sys_clk), .RST_N(rst_n), .PINS(pins),
        .POWER_STATE(pwr), .BURST_ACTIVE(burst_act), .BANK_OPEN(bank_open), .BURST_CODE(burst_code));
    spci_checker #(.DQ_W(16)) u_spci_checker (.SYS_CLK(sys_clk), .RST_N(rst_n), .cke(pins.cke),
        .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .multiplexed_address_bus(pins.multiplexed_address_bus), .low_byte_mask(pins.low_byte_mask),
        .high_byte_mask(pins.high_byte_mask), .ctl_dq_oe(pins.ctl_dq_oe), .dev_dq_oe(pins.dev_dq_oe));
    ////////////////////////////////////////////////////////////////
    // Compare, verdict and register port tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // Command write, then room for the longest burst used here
    task automatic issue(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] a);
        reg_write(OFF_CMD, {3'h0, a, 10'h000, ba, code});
        repeat (12) @(posedge sys_clk);
    endtask
    // Burst write; the model wraps inside the aligned block
    task automatic wr_op(input int c, input int l, input logic [15:0] d, input logic [1:0] m);
        int k;
        reg_write(OFF_WDATA, {14'h0, m, d});
        issue(CMD_WR, 2'h1, 13'(c));
        for (int i = 0; i < l; i++) begin
            k = (c & ~(l - 1)) | ((c + i) & (l - 1));
            mem[k] = {m[1] ? mem[k][15:8] : d[15:8], m[0] ? mem[k][7:0] : d[7:0]};
        end
    endtask
    task automatic rd_op(input int c, input int l, input logic [1:0] m);
        int k;
        k = (c & ~(l - 1)) | ((c + l - 1) & (l - 1));
        reg_write(OFF_WDATA, {14'h0, m, 16'h0});
        b = dev_beats;
        issue(CMD_RD, 2'h1, 13'(c));
        chk(32'(dev_beats - b), 32'(l));
        reg_read(OFF_RDATA, rv);
        chk(rv, {16'h0, m[1] ? 8'h00 : mem[k][15:8], m[0] ? 8'h00 : mem[k][7:0]});
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence; columns stay below 256 so storage never aliases
    initial begin
        dummy = $urandom(57289);
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        base = ($urandom % 32) * 8;
        issue(CMD_MRW, 2'h0, {10'h0, BL_8});
        issue(CMD_ACT, 2'h1, 13'($urandom));
        chk(32'(bank_open), 32'h2);
        wr_op(base, 8, 16'($urandom), 2'h0);
        for (int i = 0; i < 4; i++) begin
            issue(CMD_MRW, 2'h0, {10'h0, codes[i]});
            chk(32'(burst_code), 32'(codes[i]));
            wr_op(base + $urandom % 8, 1 << i, 16'($urandom), 2'h0);
            rd_op(base + $urandom % 8, 1 << i, 2'h0);
            rd_op(base, 1 << i, 2'h0);
        end
        $display("test bursts done");
        wr_op(base, 8, 16'($urandom), 2'h1);
        rd_op(base + 3, 8, 2'h2);
        rd_op(base + 5, 8, 2'h1);
        $display("test masks done");
        b = dev_beats;
        reg_write(OFF_CMD, {3'h0, 13'(base), 12'h001, CMD_RD});
        issue(4'hD, 2'h1, 13'(base));
        chk(32'(dev_beats - b), 32'h8);
        $display("test select done");
        reg_write(OFF_CMD, {3'h0, 13'(base), 12'h001, CMD_RD});
        reg_write(OFF_CKE, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(32'(pwr), 32'(PWR_HOLD));
        chk({31'h0, burst_act}, 32'h1);
        reg_write(OFF_CKE, 32'h1);
        repeat (12) @(posedge sys_clk);
        chk({31'h0, burst_act}, 32'h0);
        $display("test hold done");
        reg_write(OFF_CKE, 32'h0);
        repeat (4) @(posedge sys_clk);
        chk(32'(pwr), 32'(PWR_PDN_ACT));
        reg_read(OFF_STATUS, rv);
        chk({31'h0, rv[0]}, 32'h0);
        b = dev_beats;
        issue(CMD_RD, 2'h1, 13'(base));
        reg_write(OFF_CKE, 32'h1);
        repeat (4) @(posedge sys_clk);
        chk(32'(pwr), 32'(PWR_RUN));
        chk(32'(dev_beats - b), 32'h0);
        $display("test power done");
        issue(CMD_PRE, 2'h2, 13'h0000);
        chk(32'(bank_open), 32'h2);
        issue(CMD_ACT, 2'h3, 13'h0005);
        chk(32'(bank_open), 32'hA);
        issue(CMD_PRE, 2'h0, 13'h0400);
        chk(32'(bank_open), 32'h0);
        b = dev_beats;
        issue(CMD_RD, 2'h1, 13'(base));
        chk(32'(dev_beats - b), 32'h0);
        issue(CMD_ACT, 2'h1, 13'h0007);
        chk(32'(bank_open), 32'h2);
        issue(CMD_RD, 2'h1, 13'h0400 | 13'(base));
        chk(32'(bank_open), 32'h0);
        reg_write(OFF_CKE, 32'h0);
        repeat (4) @(posedge sys_clk);
        chk(32'(pwr), 32'(PWR_PDN_PRE));
        reg_write(OFF_CKE, 32'h1);
        reg_read(8'hFC, rv);
        chk(rv, 32'h0);
        $display("test rows done");
        tally_and_finish;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #400000;
        err_total++;
        tally_and_finish;
    end
endmodule
